/* File: stepdir_pkg.sv */
// Constants, types and the quarter-wave table shared by the sequencer files
package stepdir_pkg;

    // Position counter and amplitude widths
    localparam int unsigned POS_W     = 10;
    localparam int unsigned AMP_W     = 8;
    localparam int unsigned IDX_W     = 8;
    localparam int unsigned RES_W     = 4;
    localparam int unsigned QUAD_W    = 2;
    localparam int unsigned TABLE_LEN = 256;

    // Reset values
    localparam logic [POS_W-1:0] POS_RESET = 10'h000;
    localparam logic [1:0]       SYNC_RESET = 2'h0;

    // Resolution select: 0 is the finest step, 8 is fullstep; larger codes act as 8
    localparam logic [RES_W-1:0] RES_FULLSTEP = 4'h8;

    // Offsets within a quarter that mark halfstep and fullstep points
    localparam logic [IDX_W-1:0] HALFSTEP_IDX = 8'h00;
    localparam logic [IDX_W-1:0] FULLSTEP_IDX = 8'h80;

    // Table peak and quadrant shift that turns sine into cosine
    localparam logic [AMP_W-1:0]  TABLE_PEAK    = 8'hf8;
    localparam logic [QUAD_W-1:0] SINE_SHIFT    = 2'h0;
    localparam logic [QUAD_W-1:0] COSINE_SHIFT  = 2'h1;

    // Standstill timeout: 2^20 system clock cycles without an active edge
    localparam int unsigned STANDSTILL_W              = 21;
    localparam int unsigned STANDSTILL_CYCLES_DEFAULT = 1 << 20;

    // Signed coil current as sign and magnitude
    typedef struct packed {
        logic             negative;
        logic [AMP_W-1:0] magnitude;
    } coil_drive_t;

    // Synchronised step and direction levels
    typedef struct packed {
        logic step;
        logic dir;
    } pin_pair_t;

    // First quarter of the sine wave, index 0 to 255
    localparam logic [AMP_W-1:0] SINE_QUARTER [TABLE_LEN] = '{
        8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b,
        8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
        8'h19, 8'h1b, 8'h1c, 8'h1e, 8'h1f, 8'h21, 8'h22, 8'h24,
        8'h25, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2d, 8'h2e, 8'h30,
        8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3a, 8'h3c,
        8'h3d, 8'h3e, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
        8'h49, 8'h4a, 8'h4c, 8'h4d, 8'h4f, 8'h50, 8'h51, 8'h53,
        8'h54, 8'h56, 8'h57, 8'h59, 8'h5a, 8'h5b, 8'h5d, 8'h5e,
        8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
        8'h6b, 8'h6c, 8'h6d, 8'h6f, 8'h70, 8'h72, 8'h73, 8'h74,
        8'h76, 8'h77, 8'h78, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f,
        8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
        8'h8a, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h91, 8'h92, 8'h93,
        8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9c, 8'h9d,
        8'h9e, 8'h9f, 8'ha0, 8'ha1, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
        8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hac, 8'had, 8'hae, 8'haf,
        8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7,
        8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
        8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
        8'hc8, 8'hc9, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce,
        8'hcf, 8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd4,
        8'hd5, 8'hd6, 8'hd7, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hda,
        8'hdb, 8'hdc, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'hdf, 8'he0,
        8'he1, 8'he1, 8'he2, 8'he2, 8'he3, 8'he4, 8'he4, 8'he5,
        8'he5, 8'he6, 8'he7, 8'he7, 8'he8, 8'he8, 8'he9, 8'he9,
        8'hea, 8'hea, 8'heb, 8'heb, 8'hec, 8'hec, 8'hed, 8'hed,
        8'hee, 8'hee, 8'hee, 8'hef, 8'hef, 8'hf0, 8'hf0, 8'hf0,
        8'hf1, 8'hf1, 8'hf1, 8'hf2, 8'hf2, 8'hf2, 8'hf3, 8'hf3,
        8'hf3, 8'hf4, 8'hf4, 8'hf4, 8'hf4, 8'hf5, 8'hf5, 8'hf5,
        8'hf5, 8'hf6, 8'hf6, 8'hf6, 8'hf6, 8'hf6, 8'hf7, 8'hf7,
        8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf7, 8'hf8, 8'hf8,
        8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8
    };

endpackage

/* File: coil_phase_lookup.sv */
// Quarter-wave lookup that gives one coil its signed current from the position
`timescale 1ns/1ps
module coil_phase_lookup #(
    parameter logic [stepdir_pkg::QUAD_W-1:0] QUAD_SHIFT = stepdir_pkg::SINE_SHIFT
) (
    // Electrical angle
    input  wire logic [stepdir_pkg::POS_W-1:0] angle,
    // Signed coil current
    output stepdir_pkg::coil_drive_t            drive
);

    logic [stepdir_pkg::QUAD_W-1:0] quadrant;
    logic [stepdir_pkg::IDX_W-1:0]  index;
    logic [stepdir_pkg::IDX_W-1:0]  table_idx;

    // Cosine is sine shifted by one quadrant, so both coils share one table
    assign quadrant  = angle[stepdir_pkg::POS_W-1 -: stepdir_pkg::QUAD_W] + QUAD_SHIFT;
    assign index     = angle[stepdir_pkg::IDX_W-1:0];
    // Odd quadrants run the table backwards, upper half is negative
    assign table_idx = quadrant[0] ? ~index : index;
    assign drive.negative  = quadrant[1];
    assign drive.magnitude = stepdir_pkg::SINE_QUARTER[table_idx];

endmodule

/* File: step_dir_microstep_sequencer.sv */
// Step/direction front end, microstep position counter and coil current outputs
`timescale 1ns/1ps
// How it works
// - Double-edge select set: both step edges count; clear: rising edges only.
// - Step and direction pass two flip-flops before any logic reads them.
// - Electrical angle is a 10-bit unsigned microstep position counter.
// - Resolution select sets the step size added or subtracted per edge.
// - Direction low adds the step size; direction high subtracts it.
// - One quarter-wave table plus quadrant symmetry gives sine and cosine over 360.
// - Table holds 256 entries rising from 1 to a peak of 248.
// - Table contents match the listed values exactly, repeats included.
// - Positions 0, 256, 512, 768 give the halfstep coil current pairs.
// - Positions 128, 384, 640, 896 give magnitudes 175 and 176 (about 70.7%), signs ++ +- -- -+.
// - Standstill flag sets after 2^20 cycles without an edge, clears on next edge.
module step_dir_microstep_sequencer #(
    parameter int unsigned STANDSTILL_CYCLES = stepdir_pkg::STANDSTILL_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              reset,
    // Motion controller pins
    input  wire logic                              step_in,
    input  wire logic                              dir_in,
    // Drive configuration
    input  wire logic                              double_edge_select,
    input  wire logic [stepdir_pkg::RES_W-1:0]     resolution_select,
    // Position and coil currents
    output logic      [stepdir_pkg::POS_W-1:0]     microstep_position,
    output stepdir_pkg::coil_drive_t               coil_a,
    output stepdir_pkg::coil_drive_t               coil_b,
    // Status
    output logic                                   standstill_flag,
    output logic                                   halfstep_point,
    output logic                                   fullstep_point
);

    localparam logic [stepdir_pkg::STANDSTILL_W-1:0] IDLE_LIMIT =
        stepdir_pkg::STANDSTILL_W'(STANDSTILL_CYCLES - 1);
    localparam logic [stepdir_pkg::STANDSTILL_W-1:0] IDLE_ZERO  = '0;
    localparam logic [stepdir_pkg::STANDSTILL_W-1:0] IDLE_ONE   = 21'h000001;

    // Synchroniser stages
    stepdir_pkg::pin_pair_t                 pin_meta_q;
    stepdir_pkg::pin_pair_t                 pin_sync_q;
    logic                                   step_prev_q;

    // Edge detection and step size
    logic                                   rise_edge;
    logic                                   fall_edge;
    logic                                   active_edge;
    logic [stepdir_pkg::RES_W-1:0]          res_eff;
    logic [stepdir_pkg::POS_W-1:0]          step_size;

    // Position counter
    logic [stepdir_pkg::POS_W-1:0]          position_q;
    logic [stepdir_pkg::POS_W-1:0]          position_d;

    // Coil lookup and registered outputs
    stepdir_pkg::coil_drive_t               sine_drive;
    stepdir_pkg::coil_drive_t               cosine_drive;
    stepdir_pkg::coil_drive_t               coil_a_q;
    stepdir_pkg::coil_drive_t               coil_b_q;
    logic                                   halfstep_d;
    logic                                   fullstep_d;
    logic                                   halfstep_q;
    logic                                   fullstep_q;

    // Standstill detection
    logic [stepdir_pkg::STANDSTILL_W-1:0]   idle_cnt_q;
    logic [stepdir_pkg::STANDSTILL_W-1:0]   idle_cnt_d;
    logic                                   idle_timeout;
    logic                                   standstill_q;
    logic                                   standstill_d;

    // Both pins share one synchroniser so direction and step stay aligned
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_meta_q  <= stepdir_pkg::SYNC_RESET;
            pin_sync_q  <= stepdir_pkg::SYNC_RESET;
            step_prev_q <= 1'b0;
        end else begin
            pin_meta_q  <= '{step: step_in, dir: dir_in};
            pin_sync_q  <= pin_meta_q;
            step_prev_q <= pin_sync_q.step;
        end
    end

    assign rise_edge   = pin_sync_q.step & ~step_prev_q;
    assign fall_edge   = ~pin_sync_q.step & step_prev_q;
    assign active_edge = rise_edge | (double_edge_select & fall_edge);

    // Codes above fullstep would step past a quarter, and codes from 10 up would shift the increment out of the counter
    assign res_eff   = (resolution_select > stepdir_pkg::RES_FULLSTEP) ?
                       stepdir_pkg::RES_FULLSTEP : resolution_select;
    assign step_size = stepdir_pkg::POS_W'(1) << res_eff;

    // Plain 10-bit arithmetic wraps in both directions
    assign position_d = !active_edge      ? position_q :
                        pin_sync_q.dir    ? position_q - step_size :
                                            position_q + step_size;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            position_q <= stepdir_pkg::POS_RESET;
        end else begin
            position_q <= position_d;
        end
    end

    // Coil A follows sine, coil B follows cosine
    coil_phase_lookup #(
        .QUAD_SHIFT (stepdir_pkg::SINE_SHIFT)
    ) u_sine_lookup (
        .angle (position_q),
        .drive (sine_drive)
    );

    coil_phase_lookup #(
        .QUAD_SHIFT (stepdir_pkg::COSINE_SHIFT)
    ) u_cosine_lookup (
        .angle (position_q),
        .drive (cosine_drive)
    );

    // Point flags tell the controller where a resolution change is safe
    assign halfstep_d = position_q[stepdir_pkg::IDX_W-1:0] == stepdir_pkg::HALFSTEP_IDX;
    assign fullstep_d = position_q[stepdir_pkg::IDX_W-1:0] == stepdir_pkg::FULLSTEP_IDX;

    // Registered lookup adds one cycle of latency but keeps outputs glitch free
    always_ff @(posedge core_clk) begin
        if (reset) begin
            coil_a_q   <= '0;
            coil_b_q   <= '0;
            halfstep_q <= 1'b0;
            fullstep_q <= 1'b0;
        end else begin
            coil_a_q   <= sine_drive;
            coil_b_q   <= cosine_drive;
            halfstep_q <= halfstep_d;
            fullstep_q <= fullstep_d;
        end
    end

    // Idle counter saturates so it never wraps back under the limit
    assign idle_timeout = idle_cnt_q == IDLE_LIMIT;
    assign idle_cnt_d   = active_edge  ? IDLE_ZERO :
                          idle_timeout ? idle_cnt_q :
                                         idle_cnt_q + IDLE_ONE;
    // An edge always wins, since it restarts the idle interval
    assign standstill_d = active_edge ? 1'b0 :
                          idle_timeout ? 1'b1 : standstill_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            idle_cnt_q   <= IDLE_ZERO;
            standstill_q <= 1'b0;
        end else begin
            idle_cnt_q   <= idle_cnt_d;
            standstill_q <= standstill_d;
        end
    end

    assign microstep_position = position_q;
    assign coil_a             = coil_a_q;
    assign coil_b             = coil_b_q;
    assign standstill_flag    = standstill_q;
    assign halfstep_point     = halfstep_q;
    assign fullstep_point     = fullstep_q;

    // Checks on the documented behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_rise_counts: assert property (
        !step_prev_q && pin_sync_q.step |-> active_edge
    ) else $error("Rising step edge not taken as active");

    a_fall_mode: assert property (
        step_prev_q && !pin_sync_q.step |-> active_edge == double_edge_select
    ) else $error("Falling step edge handled against edge mode");

    a_single_edge: assert property (
        !double_edge_select |-> active_edge == rise_edge
    ) else $error("Falling edge counted in single-edge mode");

    a_sync_delay: assert property (
        ##3 1'b1 |-> pin_sync_q.step == $past(step_in, 2) && pin_sync_q.dir == $past(dir_in, 2)
    ) else $error("Step or direction not delayed by two flops");

    a_pos_forward: assert property (
        active_edge && !pin_sync_q.dir |=>
            position_q == $past(position_q) + $past(step_size)
    ) else $error("Position did not advance by step size");

    a_pos_backward: assert property (
        active_edge && pin_sync_q.dir |=>
            position_q == $past(position_q) - $past(step_size)
    ) else $error("Position did not retreat by step size");

    a_pos_hold: assert property (
        !active_edge |=> $stable(position_q)
    ) else $error("Position moved without an active edge");

    a_step_size: assert property (
        step_size == ((resolution_select > 4'h8) ? 10'h100 : 10'h001 << resolution_select)
    ) else $error("Step size does not follow resolution select");

    a_wrap_up: assert property (
        active_edge && !pin_sync_q.dir && position_q == 10'h3ff && step_size == 10'h001
        |=> position_q == 10'h000
    ) else $error("Position did not wrap upward to zero");

    a_wrap_down: assert property (
        active_edge && pin_sync_q.dir && position_q == 10'h000 && step_size == 10'h001
        |=> position_q == 10'h3ff
    ) else $error("Position did not wrap downward to the top");

    // Table minimum is 1, so a 0% coil still carries the smallest step of current
    a_halfstep_zero: assert property (
        position_q == 10'h000 |=> !coil_b.negative && coil_b.magnitude == 8'hf8
            && coil_a.magnitude == 8'h01 && !coil_a.negative
    ) else $error("Halfstep zero currents wrong");

    a_halfstep_one: assert property (
        position_q == 10'h100 |=> !coil_a.negative && coil_a.magnitude == 8'hf8
            && coil_b.negative && coil_b.magnitude == 8'h01
    ) else $error("Halfstep one currents wrong");

    a_halfstep_two: assert property (
        position_q == 10'h200 |=> coil_b.negative && coil_b.magnitude == 8'hf8
    ) else $error("Halfstep two coil B not full negative");

    a_halfstep_three: assert property (
        position_q == 10'h300 |=> coil_a.negative && coil_a.magnitude == 8'hf8
            && !coil_b.negative && coil_b.magnitude == 8'h01
    ) else $error("Halfstep three currents wrong");

    a_fullstep_zero: assert property (
        position_q == 10'h080 |=> !coil_a.negative && !coil_b.negative
            && coil_a.magnitude inside {8'haf, 8'hb0} && coil_b.magnitude inside {8'haf, 8'hb0}
    ) else $error("Fullstep zero currents wrong");

    a_fullstep_pair: assert property (
        position_q == 10'h180 |=> !coil_a.negative && coil_b.negative
            && coil_a.magnitude inside {8'haf, 8'hb0} && coil_b.magnitude inside {8'haf, 8'hb0}
    ) else $error("Fullstep one currents wrong");

    a_fullstep_two: assert property (
        position_q == 10'h280 |=> coil_a.negative && coil_b.negative
            && coil_a.magnitude inside {8'haf, 8'hb0} && coil_b.magnitude inside {8'haf, 8'hb0}
    ) else $error("Fullstep two currents wrong");

    a_fullstep_three: assert property (
        position_q == 10'h380 |=> coil_a.negative && !coil_b.negative
            && coil_a.magnitude inside {8'haf, 8'hb0} && coil_b.magnitude inside {8'haf, 8'hb0}
    ) else $error("Fullstep three currents wrong");

    // Point flags lag the position by the same cycle as the coil registers
    a_half_flag: assert property (
        1'b1 |=> halfstep_point == ($past(position_q[7:0]) == 8'h00)
    ) else $error("Halfstep point flag wrong");

    a_full_flag: assert property (
        1'b1 |=> fullstep_point == ($past(position_q[7:0]) == 8'h80)
    ) else $error("Fullstep point flag wrong");

    // Cosine sign flips one quadrant ahead of sine
    a_sine_sign: assert property (
        1'b1 |=> coil_a.negative == $past(position_q[9])
    ) else $error("Coil A sign does not follow the top position bit");

    a_cosine_sign: assert property (
        1'b1 |=> coil_b.negative == ($past(position_q[9]) ^ $past(position_q[8]))
    ) else $error("Coil B sign not one quadrant ahead of coil A");

    // Coil registers hold zero in reset, so the first cycle after release is skipped
    a_peak_bound: assert property (
        !$past(reset) |-> coil_a.magnitude <= 8'hf8 && coil_b.magnitude <= 8'hf8
            && coil_a.magnitude >= 8'h01 && coil_b.magnitude >= 8'h01
    ) else $error("Coil magnitude out of table range");

    a_still_clear: assert property (
        active_edge |=> !standstill_flag
    ) else $error("Standstill flag not cleared by active edge");

    a_still_set: assert property (
        $rose(standstill_flag) |-> $past(idle_cnt_q) == IDLE_LIMIT && !$past(active_edge)
    ) else $error("Standstill flag set before timeout");

    a_still_hold: assert property (
        standstill_flag && !active_edge |=> standstill_flag
    ) else $error("Standstill flag dropped without an active edge");

    a_idle_restart: assert property (
        active_edge |=> idle_cnt_q == IDLE_ZERO
    ) else $error("Idle interval not restarted by an active edge");

    a_idle_saturate: assert property (
        idle_cnt_q == IDLE_LIMIT && !active_edge |=> idle_cnt_q == IDLE_LIMIT
    ) else $error("Idle counter wrapped after the timeout");

endmodule

/* File: step_controller.sv */
// Motion controller model that issues step pulses and direction levels
`timescale 1ns/1ps
module step_controller (
    // Clock
    input  wire logic core_clk,
    // Step and direction pins
    output logic      step_in,
    output logic      dir_in
);
    initial begin
        step_in = 1'b0;
        dir_in  = 1'b0;
    end

    // Levels last at least 2 clocks so the sync flops see them; the caller
    // stretches hi and lo to keep the fullstep rate low enough
    task automatic pulse(input logic dir, input int hi, input int lo);
        @(negedge core_clk) dir_in <= dir;
        repeat (2) @(negedge core_clk);
        step_in <= 1'b1;
        repeat ((hi < 2) ? 2 : hi) @(negedge core_clk);
        step_in <= 1'b0;
        repeat ((lo < 2) ? 2 : lo) @(negedge core_clk);
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the step/direction microstep sequencer
`timescale 1ns/1ps
module testbench;
    localparam int unsigned STILL = 16;

    logic                          core_clk;
    logic                          reset;
    logic                          step_in;
    logic                          dir_in;
    logic                          double_edge_select;
    logic [stepdir_pkg::RES_W-1:0] resolution_select;
    logic [stepdir_pkg::POS_W-1:0] microstep_position;
    stepdir_pkg::coil_drive_t      coil_a;
    stepdir_pkg::coil_drive_t      coil_b;
    logic                          standstill_flag;
    logic                          halfstep_point;
    logic                          fullstep_point;
    logic [stepdir_pkg::POS_W-1:0] exp_pos;
    int                            n_errors;
    int                            checks_done;
    int                            seed;
    int                            cycles = 0;
    // Coil pairs {a, b} at positions 0, 128, ... 896
    logic [17:0]                   hand [8] = '{18'h002f8, 18'h160af, 18'h1f101,
        18'h15fb0, 18'h203f8, 18'h361af, 18'h3f001, 18'h35eb0};

    step_controller ctl (
        .core_clk (core_clk),
        .step_in  (step_in),
        .dir_in   (dir_in)
    );

    step_dir_microstep_sequencer #(.STANDSTILL_CYCLES(STILL)) dut (
        .core_clk           (core_clk),
        .reset              (reset),
        .step_in            (step_in),
        .dir_in             (dir_in),
        .double_edge_select (double_edge_select),
        .resolution_select  (resolution_select),
        .microstep_position (microstep_position),
        .coil_a             (coil_a),
        .coil_b             (coil_b),
        .standstill_flag    (standstill_flag),
        .halfstep_point     (halfstep_point),
        .fullstep_point     (fullstep_point)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic stepdir_pkg::coil_drive_t wave(input logic [9:0] p);
        logic [7:0] i;
        i = p[8] ? ~p[7:0] : p[7:0];
        return {p[9], stepdir_pkg::SINE_QUARTER[i]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic check_outputs();
        check(32'(microstep_position), 32'(exp_pos), "position");
        check(32'(coil_a), 32'(wave(exp_pos)), "coil a");
        check(32'(coil_b), 32'(wave(exp_pos + 10'h100)), "coil b");
        check(32'(halfstep_point), 32'(exp_pos[7:0] == 8'h00), "halfstep point");
        check(32'(fullstep_point), 32'(exp_pos[7:0] == 8'h80), "fullstep point");
    endtask

    // Gaps grow with the step size so fullsteps come no faster than clock/512
    task automatic do_step(input logic d, input int extra);
        int k;
        int gap;
        k = (resolution_select > 4'h8) ? 8 : int'(resolution_select);
        gap = (2 << k) + extra;
        ctl.pulse(d, gap, gap);
        repeat (double_edge_select ? 2 : 1)
            exp_pos = d ? exp_pos - (10'h1 << k) : exp_pos + (10'h1 << k);
        repeat (4) @(negedge core_clk);
        check_outputs();
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        seed = 32'h1cc5;
        n_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        double_edge_select = 1'b0;
        resolution_select = 4'h0;
        exp_pos = '0;
        repeat (16) @(negedge core_clk);
        check(32'(standstill_flag), 32'h0, "flag in reset");
        reset = 1'b0;
        @(negedge core_clk);
        check_outputs();
        $display("test reset done");
        do_step(1'b1, 0);
        do_step(1'b0, 0);
        $display("test wrap done");
        // Coarse resolution entered here at a halfstep point, position 0
        resolution_select = 4'h7;
        for (int i = 1; i <= 8; i++) begin
            do_step(1'b0, 0);
            check(32'({coil_a, coil_b}), 32'(hand[i % 8]), "step point");
        end
        $display("test step points done");
        for (int c = 0; c < 16; c++) begin
            resolution_select = 4'(c);
            double_edge_select = c[0];
            do_step(1'($random(seed)), 0);
            do_step(1'($random(seed)), 0);
        end
        $display("test codes done");
        for (int n = 0; n < 200; n++) begin
            resolution_select = 4'($random(seed) & 32'h3);
            double_edge_select = 1'($random(seed));
            do_step(1'($random(seed)), $random(seed) & 32'h3);
        end
        $display("test random done");
        double_edge_select = 1'b0;
        resolution_select = 4'h0;
        repeat (STILL + 8) @(negedge core_clk);
        check(32'(standstill_flag), 32'h1, "flag idle");
        do_step(1'b0, 0);
        check(32'(standstill_flag), 32'h0, "flag after edge");
        repeat (STILL + 4) @(negedge core_clk);
        check(32'(standstill_flag), 32'h1, "flag again");
        $display("test standstill done");
        resolution_select = 4'h4;
        do_step(1'b0, 0);
        reset = 1'b1;
        repeat (3) @(negedge core_clk);
        check(32'(standstill_flag), 32'h0, "flag in reset");
        reset = 1'b0;
        exp_pos = '0;
        @(negedge core_clk);
        check_outputs();
        do_step(1'b1, 0);
        $display("test second reset done");
        stop_test();
    end
endmodule
